//--- core/slcd_defines.vh
// constants of the segment lcd pattern driver: register map, fields, patterns, timing.
// assumes a 200 MHz system clock and a 32768 Hz pre-divider source derived from it.
`ifndef SLCD_DEFINES_VH
`define SLCD_DEFINES_VH

// register byte offsets on the wishbone slave
`define SLCD_ADR_CTRL 8'h00
`define SLCD_ADR_LOAD 8'h04
`define SLCD_ADR_STAT 8'h08

// control register bits (write = instruction, read bit0 = display off)
`define SLCD_CTRL_OFF 0
`define SLCD_CTRL_ON 1

// load register fields
`define SLCD_LD_DATA 7:0
`define SLCD_LD_SEL 12:8
`define SLCD_LD_OP 17:16

// load operations
`define SLCD_OP_DEC 2'h0
`define SLCD_OP_BLK 2'h1
`define SLCD_OP_RAW 2'h2
`define SLCD_OP_TBL 2'h3

// drive level codes: gnd, one third (or half rail), two thirds, vdd
`define SLCD_LV_GND 2'h0
`define SLCD_LV_LO 2'h1
`define SLCD_LV_HI 2'h2
`define SLCD_LV_VDD 2'h3

// bias option codes
`define SLCD_BIAS_NONE 0
`define SLCD_BIAS_HALF 2
`define SLCD_BIAS_THIRD 3

// frame speed option codes
`define SLCD_FR_OFF 0
`define SLCD_FR_SLOW 1
`define SLCD_FR_TYP 2
`define SLCD_FR_FAST 3

// digit patterns, bit0 = segment a ... bit7 = segment h
`define SLCD_DIG_0 8'hBF
`define SLCD_DIG_1 8'h86
`define SLCD_DIG_2 8'hDB
`define SLCD_DIG_3 8'hCF
`define SLCD_DIG_4 8'hE6
`define SLCD_DIG_5 8'hED
`define SLCD_DIG_6 8'hFD
`define SLCD_DIG_7 8'h87
`define SLCD_DIG_8 8'hFF
`define SLCD_DIG_9 8'hEF
`define SLCD_DIG_F 5

// timing: system clock and pre-divider source, in hertz
`define SLCD_CLK_HZ 200000000
`define SLCD_SRC_HZ 32768
`define SLCD_PRE_DIV (`SLCD_CLK_HZ / `SLCD_SRC_HZ)

// common slot length in source ticks at typical speed per duty, then the fast third-duty slot
`define SLCD_SLOT_D1 1024
`define SLCD_SLOT_D2 512
`define SLCD_SLOT_D3 260
`define SLCD_SLOT_D4 256
`define SLCD_SLOT_D5 128
`define SLCD_SLOT_D3_FAST 128

`endif

//--- core/slcd_digit_dec.v
// seven-segment digit decoder feeding the pattern bus.
// purely combinational; the caller registers the result.
`timescale 1ns/10ps
`include "slcd_defines.vh"

module slcd_digit_dec #(
  parameter F7_ON = 1
) (
  input wire [3:0] nibble_i,
  input wire blank_i,
  output reg [7:0] pattern_o
);

  // table lookup; a-f give an empty pattern
  always @*
  begin
    case (nibble_i)
      4'h0: pattern_o = blank_i ? 8'h00 : `SLCD_DIG_0; // leading zero blanking
      4'h1: pattern_o = `SLCD_DIG_1;
      4'h2: pattern_o = `SLCD_DIG_2;
      4'h3: pattern_o = `SLCD_DIG_3;
      4'h4: pattern_o = `SLCD_DIG_4;
      4'h5: pattern_o = `SLCD_DIG_5;
      4'h6: pattern_o = `SLCD_DIG_6;
      4'h7:
      begin
        pattern_o = `SLCD_DIG_7;
        pattern_o[`SLCD_DIG_F] = (F7_ON != 0); // shape of seven fixed at build
      end
      4'h8: pattern_o = `SLCD_DIG_8;
      4'h9: pattern_o = `SLCD_DIG_9;
      default: pattern_o = 8'h00;
    endcase
  end

endmodule

//--- core/slcd_driver.v
// segment lcd pattern driver: pattern bus, pixel latches, mux and drive levels.
// assumes a classic wishbone master on clock_i and a same-clock stop_i level.
// Contract
// - thirty-five segment and five common outputs
// - segments one to twenty-three may be dc
// - duty and bias separate, third bias needs duty>=3
// - frames derived from 32768 Hz source
// - half duty frames 16, 32, 64 Hz
// - third duty frames 21, 42, 85 Hz
// - quarter duty frames 16, 32, 64 Hz
// - fifth duty frames 25, 51, 102 Hz
// - reset shows build default until first load
// - digits zero-nine decoded, a-f blank
// - segment f of seven is build choice
// - blanked load zeros bus for nibble zero
// - raw load: register low, accumulator high
// - table load puts rom word on bus
// - latch select picks one of 32 strobes
// - 175 pixel latches drive the panel
// - each latch wired to bus bit, strobe
// - display off blanks, on restores, latches kept
// - loads still update latches while off
// - stop state grounds every common and segment
// - dc pins hold data through stop, off
// - common field 0 push-pull, 9 open-drain
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`include "slcd_defines.vh"

module slcd_driver #(
  parameter SEG_N = 35,
  parameter COM_N = 5,
  parameter DUTY = 4,
  parameter BIAS = `SLCD_BIAS_THIRD,
  parameter FRAME_SEL = `SLCD_FR_TYP,
  parameter RESET_ON = 0,
  parameter F7_ON = 1,
  parameter DC_MAX = 23,
  parameter PRE_DIV = `SLCD_PRE_DIV,
  parameter USE_DEF_PLA = 1,
  parameter [SEG_N*4-1:0] SEG_COMSEL = {SEG_N{4'h1}},
  parameter [SEG_N*COM_N*5-1:0] PIX_STB = {(SEG_N*COM_N*5){1'b0}},
  parameter [SEG_N*COM_N*3-1:0] PIX_BIT = {(SEG_N*COM_N*3){1'b0}}
) (
  input wire clock_i,
  input wire resetn_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire stop_i,
  output wire [COM_N*2-1:0] com_lvl_o,
  output wire [SEG_N*2-1:0] seg_lvl_o,
  output wire [SEG_N-1:0] seg_dc_o,
  output wire [SEG_N-1:0] seg_dc_oen_o
);

  localparam PIX_N = SEG_N * COM_N; // one latch per crossing
  localparam NCOM = (DUTY < 1) ? 1 : DUTY;
  // third bias falls back to half bias at half duty; static duty has no bias
  localparam EBIAS = (NCOM == 1) ? `SLCD_BIAS_NONE :
                     ((BIAS == `SLCD_BIAS_THIRD) && (NCOM < 3)) ? `SLCD_BIAS_HALF : BIAS;
  localparam SLOT_TYP = (NCOM == 1) ? `SLCD_SLOT_D1 :
                        (NCOM == 2) ? `SLCD_SLOT_D2 :
                        (NCOM == 3) ? `SLCD_SLOT_D3 :
                        (NCOM == 4) ? `SLCD_SLOT_D4 : `SLCD_SLOT_D5;
  // slot lengths give the frame rates per duty
  localparam SLOT_LEN = (FRAME_SEL == `SLCD_FR_SLOW) ? SLOT_TYP * 2 :
                        (FRAME_SEL == `SLCD_FR_FAST) ?
                        ((NCOM == 3) ? `SLCD_SLOT_D3_FAST : SLOT_TYP / 2) : SLOT_TYP;
  // terminal counts worked out at full width, then cut to the counter widths
  // limitation: a pre-divider above 65536 does not fit the 16-bit prescaler
  localparam [31:0] PRE_LAST_W = PRE_DIV - 1;
  localparam [31:0] SLOT_LAST_W = SLOT_LEN - 1;
  localparam [31:0] COM_LAST_W = NCOM - 1;
  localparam [15:0] PRE_LAST = PRE_LAST_W[15:0];
  localparam [11:0] SLOT_LAST = SLOT_LAST_W[11:0];
  localparam [2:0] COM_LAST = COM_LAST_W[2:0];
  localparam RUN = (FRAME_SEL != `SLCD_FR_OFF);

  reg ack_ff;
  reg [31:0] dat_ff;
  reg disp_off_ff;
  reg [7:0] pat_bus_ff;
  reg strobe_go_ff;
  reg [4:0] strobe_idx_ff;
  reg [15:0] pre_cnt_ff;
  reg tick_ff;
  reg [11:0] slot_cnt_ff;
  reg [2:0] com_idx_ff;
  reg pol_ff;
  reg [7:0] nxt_bus;
  reg [31:0] nxt_dat;
  wire [7:0] dec_bus;
  wire [PIX_N-1:0] pix_w;
  wire req;
  wire wr_load;
  wire wr_ctrl;
  wire blank;

  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_load = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `SLCD_ADR_LOAD);
  assign wr_ctrl = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `SLCD_ADR_CTRL);
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // off, stop and an unused frame setting all ground the panel
  assign blank = disp_off_ff | stop_i | ~RUN;

  // decoder is shared by both decoded loads
  slcd_digit_dec #(
    .F7_ON(F7_ON)
  ) u_dec (
    .nibble_i(wb_dat_i[3:0]),
    .blank_i(wb_dat_i[17:16] == `SLCD_OP_BLK),
    .pattern_o(dec_bus)
  );

  // pattern bus source per load kind
  always @*
  begin
    case (wb_dat_i[`SLCD_LD_OP])
      `SLCD_OP_RAW: nxt_bus = {wb_dat_i[7:4], wb_dat_i[3:0]}; // acc high, reg low
      `SLCD_OP_TBL: nxt_bus = wb_dat_i[`SLCD_LD_DATA]; // rom word bits in order
      default: nxt_bus = dec_bus;
    endcase
  end

  // read mux; unmapped offsets read zero but still ack
  always @*
  begin
    nxt_dat = 32'h0000_0000;
    case (wb_adr_i)
      `SLCD_ADR_CTRL: nxt_dat[0] = disp_off_ff;
      `SLCD_ADR_STAT:
      begin
        nxt_dat[2:0] = com_idx_ff;
        nxt_dat[3] = pol_ff;
        nxt_dat[4] = blank;
        nxt_dat[15:8] = pat_bus_ff;
      end
      default: nxt_dat = 32'h0000_0000;
    endcase
  end

  // wishbone slave: ack one cycle after the request, dropped the next cycle
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= req;
      if (req & ~wb_we_i)
        dat_ff <= nxt_dat;
    end
  end

  // display on/off instructions touch no latch
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      disp_off_ff <= 1'b0;
    else if (wr_ctrl)
    begin
      if (wb_dat_i[`SLCD_CTRL_OFF])
        disp_off_ff <= 1'b1; // off wins when both bits are written
      else if (wb_dat_i[`SLCD_CTRL_ON])
        disp_off_ff <= 1'b0;
    end
  end

  // bus and strobe staged one cycle so latches see a settled pattern
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pat_bus_ff <= 8'h00;
      strobe_go_ff <= 1'b0;
      strobe_idx_ff <= 5'h00;
    end
    else
    begin
      strobe_go_ff <= wr_load; // loads proceed regardless of display state
      if (wr_load)
      begin
        pat_bus_ff <= nxt_bus;
        strobe_idx_ff <= wb_dat_i[`SLCD_LD_SEL]; // one of 32 strobes
      end
    end
  end

  // source tick at 32768 Hz from the system clock
  // the divider is a floor, so the tick runs a hair fast rather than slow
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pre_cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= (pre_cnt_ff == PRE_LAST);
      if (pre_cnt_ff == PRE_LAST)
        pre_cnt_ff <= 16'h0000;
      else
        pre_cnt_ff <= pre_cnt_ff + 16'h0001;
    end
  end

  // common scan; polarity flips at each frame end so each pixel averages zero
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      slot_cnt_ff <= 12'h000;
      com_idx_ff <= 3'h0;
      pol_ff <= 1'b0;
    end
    else if (tick_ff & RUN)
    begin
      if (slot_cnt_ff == SLOT_LAST)
      begin
        slot_cnt_ff <= 12'h000;
        if (com_idx_ff == COM_LAST)
        begin
          com_idx_ff <= 3'h0; // fixed scan order
          pol_ff <= ~pol_ff;
        end
        else
          com_idx_ff <= com_idx_ff + 3'h1;
      end
      else
        slot_cnt_ff <= slot_cnt_ff + 12'h001;
    end
  end

  // pixel latches with segment pla wiring fixed per latch
  genvar i;
  generate
    for (i = 0; i < PIX_N; i = i + 1)
    begin : g_pix
      localparam [31:0] PS_DEF = (i / 8) % 32;
      localparam [31:0] PB_DEF = i % 8;
      localparam [4:0] PS = USE_DEF_PLA ? PS_DEF[4:0] : PIX_STB[i*5 +: 5];
      localparam [2:0] PB = USE_DEF_PLA ? PB_DEF[2:0] : PIX_BIT[i*3 +: 3];
      reg q_ff;
      // reset default held until the first matching strobe
      always @(posedge clock_i or negedge resetn_i)
      begin
        if (!resetn_i)
          q_ff <= (RESET_ON != 0);
        else if (strobe_go_ff && (strobe_idx_ff == PS))
          q_ff <= pat_bus_ff[PB];
      end
      assign pix_w[i] = q_ff;
    end
  endgenerate

  // common drivers: selected rail alternates, other scanned commons sit at the bias level, unscanned ones at ground
  genvar c;
  generate
    for (c = 0; c < COM_N; c = c + 1)
    begin : g_com
      reg [1:0] lvl_ff;
      always @(posedge clock_i or negedge resetn_i)
      begin
        if (!resetn_i)
          lvl_ff <= `SLCD_LV_GND;
        else if (blank || (c >= NCOM))
          lvl_ff <= `SLCD_LV_GND;
        else if (com_idx_ff == c)
          lvl_ff <= pol_ff ? `SLCD_LV_VDD : `SLCD_LV_GND;
        else if (EBIAS == `SLCD_BIAS_THIRD)
          lvl_ff <= pol_ff ? `SLCD_LV_LO : `SLCD_LV_HI;
        else
          lvl_ff <= `SLCD_LV_LO; // half rail for half bias
      end
      assign com_lvl_o[c*2 +: 2] = lvl_ff;
    end
  endgenerate

  // segment drivers; dc pins bypass mux, blanking and stop entirely
  genvar s;
  generate
    for (s = 0; s < SEG_N; s = s + 1)
    begin : g_seg
      localparam [3:0] CS = SEG_COMSEL[s*4 +: 4];
      // only the low pins may become dc ports
      localparam IS_DC = (s < DC_MAX) && ((CS == 4'h0) || (CS == 4'h9));
      localparam IS_OD = IS_DC && (CS == 4'h9);
      wire [COM_N-1:0] col;
      wire on;
      reg [1:0] lvl_ff;
      reg dc_ff;
      reg oen_ff;
      assign col = pix_w[s*COM_N +: COM_N];
      assign on = col[com_idx_ff]; // latch of this segment and active common
      always @(posedge clock_i or negedge resetn_i)
      begin
        if (!resetn_i)
          lvl_ff <= `SLCD_LV_GND;
        else if (IS_DC || blank)
          lvl_ff <= `SLCD_LV_GND;
        else if (on)
          lvl_ff <= pol_ff ? `SLCD_LV_GND : `SLCD_LV_VDD; // opposite rail lights
        else if (EBIAS == `SLCD_BIAS_THIRD)
          lvl_ff <= pol_ff ? `SLCD_LV_HI : `SLCD_LV_LO;
        else
          lvl_ff <= pol_ff ? `SLCD_LV_VDD : `SLCD_LV_GND; // same rail stays dark
      end
      assign seg_lvl_o[s*2 +: 2] = lvl_ff;
      // dc data comes from the first-common latch, registered like every data output;
      // stop and off never reach it, so the port keeps its value through both
      always @(posedge clock_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          dc_ff <= IS_DC && (RESET_ON != 0);
          oen_ff <= !IS_DC || (IS_OD && (RESET_ON == 0));
        end
        else
        begin
          dc_ff <= IS_DC && col[0];
          // open drain drives only its high level; push-pull always drives
          oen_ff <= !IS_DC || (IS_OD && !col[0]);
        end
      end
      assign seg_dc_o[s] = dc_ff;
      assign seg_dc_oen_o[s] = oen_ff;
    end
  endgenerate

endmodule

//--- tb/slcd_driver_monitor.sv
// concurrent checks on the segment lcd pattern driver ports.
// assumes the bench build: pin 0 push-pull dc, pin 1 open-drain dc, four commons scanned.
`timescale 1ns/10ps
`include "slcd_defines.vh"
module slcd_driver_monitor #(
  parameter SEG_N = 35,
  parameter COM_N = 5,
  parameter RESET_ON = 0
) (
  input logic clock_i,
  input logic resetn_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic wb_ack_o,
  input logic stop_i,
  input logic [COM_N*2-1:0] com_lvl_o,
  input logic [SEG_N*2-1:0] seg_lvl_o,
  input logic [SEG_N-1:0] seg_dc_o,
  input logic [SEG_N-1:0] seg_dc_oen_o
);
  logic [3:0] selc;
  logic wr_ctl;
  // commons on a rail level; exactly one while the panel is driven
  always_comb
  begin
    for (int k = 0; k < 4; k++)
      selc[k] = com_lvl_o[2*k+:2] inside {2'h0, 2'h3};
  end
  // control write completing at this edge
  assign wr_ctl = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_ack_o
    && wb_adr_i == `SLCD_ADR_CTRL;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  reset_dflt_a: assert property ($past(resetn_i) == 1'b0 |->
    seg_dc_o[1:0] == (RESET_ON ? 2'b11 : 2'b00)) else $error("reset default lost");
  stop_gnd_a: assert property (stop_i [*3] |-> com_lvl_o == 0 && seg_lvl_o == 0)
    else $error("stop left a level on");
  dc_hold_a: assert property (!$past(wb_cyc_i) && !$past(wb_cyc_i, 2) |->
    $stable(seg_dc_o)) else $error("dc pin moved without a load");
  dc_oen_a: assert property (seg_dc_oen_o[1:0] == {~seg_dc_o[1], 1'b0})
    else $error("dc enable wrong");
  nondc_pins_a: assert property (seg_dc_o[SEG_N-1:2] == 0 && seg_lvl_o[3:0] == 0
    && &seg_dc_oen_o[SEG_N-1:2]) else $error("dc and lcd pins mixed");
  one_common_a: assert property (com_lvl_o[7:0] != 0 |-> $onehot(selc))
    else $error("not one common selected");
  off_blank_a: assert property (wr_ctl && wb_dat_i[0] |->
    ##[1:4] (com_lvl_o == 0 && seg_lvl_o == 0)) else $error("display off not blank");
  on_show_a: assert property (wr_ctl && wb_dat_i[1:0] == 2'b10 && !stop_i |->
    ##[1:4] com_lvl_o != 0) else $error("display on stayed blank");
endmodule
bind slcd_driver slcd_driver_monitor #(.SEG_N(SEG_N), .COM_N(COM_N), .RESET_ON(RESET_ON)) mon_u (
  .clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .stop_i(stop_i), .com_lvl_o(com_lvl_o), .seg_lvl_o(seg_lvl_o),
  .seg_dc_o(seg_dc_o), .seg_dc_oen_o(seg_dc_oen_o));

//--- tb/slcd_panel_model.sv
// behavioural glass panel: finds the scanned common, lit segments and frame period.
// assumes level codes 0..3 from gnd to vdd on every pin.
`timescale 1ns/10ps
module slcd_panel_model #(
  parameter SEG_N = 35,
  parameter COM_N = 5
) (
  input logic clock_i,
  input logic [COM_N*2-1:0] com_lvl_i,
  input logic [SEG_N*2-1:0] seg_lvl_i,
  output logic [SEG_N-1:0] lit_o,
  output logic [2:0] active_o,
  output logic [31:0] period_o = 0
);
  logic [31:0] cnt_ff = 0;
  logic was0_ff = 0;
  logic [1:0] cl;
  // a pixel only sees full swing between opposite rails; lowest selected common wins
  always_comb
  begin
    active_o = 3'h7;
    cl = 2'h1;
    for (int k = COM_N - 1; k >= 0; k--)
      if (com_lvl_i != 0 && com_lvl_i[2*k+:2] inside {2'h0, 2'h3})
      begin
        active_o = k[2:0];
        cl = com_lvl_i[2*k+:2];
      end
    for (int s = 0; s < SEG_N; s++)
      lit_o[s] = {seg_lvl_i[2*s+:2], cl} inside {4'h3, 4'hC};
  end
  // frame period between entries of common 0, so a slow flickering rate shows up
  always @(posedge clock_i)
  begin
    was0_ff <= active_o == 0;
    cnt_ff <= (active_o == 0 && !was0_ff) ? 1 : cnt_ff + 1;
    if (active_o == 0 && !was0_ff)
      period_o <= cnt_ff;
  end
endmodule

//--- tb/tb.sv
// self-checking bench: wishbone loads, display off/on, stop and panel scan.
// assumes one 200 MHz clock and the design's register offsets.
`timescale 1ns/10ps
`include "slcd_defines.vh"
module tb;
  localparam PD = 4;
  localparam [139:0] CSEL = {{33{4'h1}}, 4'h9, 4'h0};
  localparam [127:0] DIGS = {48'h0, 8'hEF, 8'hFF, 8'h87, 8'hFD, 8'hED, 8'hE6, 8'hCF,
    8'hDB, 8'h86, 8'hBF};
  logic clock_i = 0, resetn_i = 0, cyc = 0, stb = 0, we = 0, stop = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [3:0] bsel = 4'hF;
  logic [31:0] wdat = 0, q;
  logic [1:0] v;
  wire [31:0] rdat, per;
  wire ack;
  wire [9:0] common_output;
  wire [69:0] seg;
  wire [34:0] dc, oen, lit;
  wire [2:0] act;
  int n_mismatch = 0, check_count = 0;
  always #2.5 clock_i = ~clock_i;
  slcd_driver #(.PRE_DIV(PD), .F7_ON(0), .SEG_COMSEL(CSEL)) dut_u (.clock_i(clock_i),
    .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .stop_i(stop),
    .com_lvl_o(common_output), .seg_lvl_o(seg), .seg_dc_o(dc), .seg_dc_oen_o(oen));
  slcd_panel_model panel_u (.clock_i(clock_i), .com_lvl_i(common_output), .seg_lvl_i(seg),
    .lit_o(lit), .active_o(act), .period_o(per));
  task end_sim;
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one classic cycle; hold everything until ack is sampled, then drop cyc, stb and we
  task wb(input [7:0] a, input w, input [31:0] d);
    int n;
    @(posedge clock_i);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, bsel};
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20)
      chk(0, 1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask
  // pattern load, then read back the pattern bus and the dc pins fed by strobe 0
  task lc(input [1:0] op, input [4:0] s, input [7:0] d, input [7:0] e);
    wb(`SLCD_ADR_LOAD, 1, {14'h0, op, 3'h0, s, d});
    wb(`SLCD_ADR_STAT, 0, 0);
    chk(q[15:8], e);
    if (s == 0)
      chk(dc[1:0], {e[5], e[0]});
  endtask
  task wact(input [2:0] c);
    for (int n = 0; n < 5000 && act !== c; n++)
      @(posedge clock_i);
    if (act !== c)
      chk(act, c);
  endtask
  initial
  begin
    repeat (12) @(posedge clock_i);
    resetn_i <= 1;
    @(posedge clock_i);
    chk(dc[1:0], 0);
    chk(oen[2:0], 3'b110);
    wb(8'h10, 0, 0);
    chk(q, 0);
    wb(`SLCD_ADR_CTRL, 0, 0);
    chk(q[0], 0);
    for (int i = 0; i < 16; i++)
    begin
      lc(`SLCD_OP_DEC, 0, i, DIGS[i*8+:8]);
      lc(`SLCD_OP_BLK, 0, i, i ? DIGS[i*8+:8] : 8'h00);
    end
    lc(`SLCD_OP_RAW, 0, 8'h5A, 8'h5A);
    lc(`SLCD_OP_TBL, 0, 8'hC3, 8'hC3);
    lc(`SLCD_OP_RAW, 0, 8'h21, 8'h21);
    chk(oen[1:0], 2'b00);
    lc(`SLCD_OP_TBL, 1, 8'hFB, 8'hFB);
    chk(dc[1:0], 2'b11);
    // a load without its low byte lane must leave bus and latches alone
    bsel = 4'hE;
    wb(`SLCD_ADR_LOAD, 1, {14'h0, `SLCD_OP_TBL, 8'h00, 8'h00});
    bsel = 4'hF;
    wb(`SLCD_ADR_STAT, 0, 0);
    chk(q[15:8], 8'hFB);
    chk(dc[1:0], 2'b11);
    wb(`SLCD_ADR_CTRL, 1, 1);
    repeat (4) @(posedge clock_i);
    chk(|{common_output, seg}, 0);
    wb(`SLCD_ADR_CTRL, 0, 0);
    chk(q[0], 1);
    lc(`SLCD_OP_TBL, 1, 8'h04, 8'h04);
    wb(`SLCD_ADR_CTRL, 1, 2);
    repeat (4) @(posedge clock_i);
    chk(|common_output, 1);
    stop <= 1;
    repeat (4) @(posedge clock_i);
    chk(|{common_output, seg}, 0);
    chk(dc[1:0], 2'b11);
    stop <= 0;
    wact(1);
    wact(0);
    repeat (500) @(posedge clock_i);
    chk(lit[2], 1);
    v = common_output[1:0];
    wact(1);
    repeat (500) @(posedge clock_i);
    chk(lit[2], 0);
    wact(0);
    repeat (500) @(posedge clock_i);
    chk(common_output[1:0], 2'h3 - v);
    chk(lit[2], 1);
    chk(per, PD * 1024);
    end_sim;
  end
  // watchdog well beyond the few frames the sequence needs
  initial
  begin
    #300000;
    n_mismatch++;
    end_sim;
  end
endmodule
